// [logic/hps_pkg.sv]
// Package: constants, states and carrier structs of the handset power sequencer
package hps_pkg;

   // ---------------------------------------------------------------
   // Clock and time base
   // ---------------------------------------------------------------
   localparam int CLK_MHZ = 125;
   // Tick period of the internal time base, in microseconds
   localparam int TICK_US = 1;
   localparam int TICK_CYC = TICK_US * CLK_MHZ;

   // ---------------------------------------------------------------
   // Times in microseconds, counts in ticks
   // ---------------------------------------------------------------
   localparam int DEBOUNCE_US  = 32000;
   localparam int LDO_STD_US   = 125;
   localparam int LDO_OPT_US   = 10000;
   localparam int RST_DELAY_US = 20000;
   localparam int HOLD_MAX_US  = 500000;

   localparam int DEBOUNCE_TK  = DEBOUNCE_US / TICK_US;
   localparam int LDO_STD_TK   = LDO_STD_US / TICK_US;
   localparam int LDO_OPT_TK   = LDO_OPT_US / TICK_US;
   localparam int RST_DELAY_TK = RST_DELAY_US / TICK_US;
   localparam int HOLD_MAX_TK  = HOLD_MAX_US / TICK_US;

   localparam int TMR_W  = 20;
   localparam int TICK_W = 8;

   // ---------------------------------------------------------------
   // Sequencer states (one-hot)
   // ---------------------------------------------------------------
   typedef enum logic [8:0] {
      ST_OFF      = 9'h001,
      ST_UP1      = 9'h002,
      ST_UP2      = 9'h004,
      ST_RSTWAIT  = 9'h008,
      ST_HOLDWAIT = 9'h010,
      ST_ON       = 9'h020,
      ST_DN_RST   = 9'h040,
      ST_DN2      = 9'h080,
      ST_DN1      = 9'h100
   } hps_state_t;

   // Rail-good comparator flags
   typedef struct packed {
      logic first95;
      logic second95;
      logic first90;
      logic second90;
   } hps_rails_t;

   // Regulator enables
   typedef struct packed {
      logic first;
      logic second;
   } hps_regs_t;

endpackage : hps_pkg

// [logic/hps_sequencer.sv]
// Power-on and power-off sequencer of a handset power management block
`timescale 1ns/1ns
`default_nettype none

module hps_sequencer
   import hps_pkg::*;
#(
   // Clock cycles per time-base tick, at most 256; lowering it shortens every delay alike
   parameter int TICK_DIV = TICK_CYC
)
(
   // Clock and reset
   input  wire logic       clk,
   input  wire logic       rst,
   // Pins from key, charger and host
   input  wire logic       power_key_in,
   input  wire logic       charger_detect_n,
   input  wire logic       host_power_hold,
   input  wire logic       backlight_enable,
   input  wire logic       optDelaySel,
   // Rail comparators
   input  wire hps_rails_t railFlags,
   // Outputs
   output var  hps_regs_t  regEnable,
   output var  logic       hostReset_n,
   output var  logic       wakeReq_n,
   output var  logic       backlight_sink,
   output var  logic       chargerSeen
);

   // ---------------------------------------------------------------
   // Input synchronisers: three stages, change when last two agree
   // ---------------------------------------------------------------
   localparam int NSYNC = 8;
   wire  [NSYNC-1:0] rawIn = {railFlags, optDelaySel, backlight_enable,
                              host_power_hold, power_key_in};
   logic [NSYNC-1:0] syncA_q;
   logic [NSYNC-1:0] syncB_q;
   logic [NSYNC-1:0] syncC_q;
   logic [NSYNC-1:0] clean_q;
   logic             vextA_q;
   logic             vextB_q;
   logic             vextC_q;
   logic             vextClean_q;

   genvar gi;
   generate
      for (gi = 0; gi < NSYNC; gi++)
      begin : g_sync
         always_ff @(posedge clk or posedge rst)
         begin
            if (rst)
            begin
               syncA_q[gi] <= 1'b0;
               syncB_q[gi] <= 1'b0;
               syncC_q[gi] <= 1'b0;
               clean_q[gi] <= 1'b0;
            end
            else
            begin
               syncA_q[gi] <= rawIn[gi];
               syncB_q[gi] <= syncA_q[gi];
               syncC_q[gi] <= syncB_q[gi];
               if (syncB_q[gi] == syncC_q[gi])
                  clean_q[gi] <= syncC_q[gi];
            end
         end
      end
   endgenerate

   // Charger detect idles high, so its chain resets to one
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         vextA_q     <= 1'b1;
         vextB_q     <= 1'b1;
         vextC_q     <= 1'b1;
         vextClean_q <= 1'b1;
      end
      else
      begin
         vextA_q <= charger_detect_n;
         vextB_q <= vextA_q;
         vextC_q <= vextB_q;
         if (vextB_q == vextC_q)
            vextClean_q <= vextC_q;
      end
   end

   wire keyIn   = clean_q[0];
   wire holdIn  = clean_q[1];
   wire blIn    = clean_q[2];
   wire optSel  = clean_q[3];
   // Comparator flags stay internal; nothing drives them out
   wire first90  = clean_q[5];
   wire second90 = clean_q[4];
   wire second95 = clean_q[6];
   wire first95  = clean_q[7];
   wire chgIn   = ~vextClean_q;

   // ---------------------------------------------------------------
   // Time base
   // ---------------------------------------------------------------
   logic [TICK_W-1:0] tickCnt_q;
   logic              tick_q;
   wire               tickWrap = (tickCnt_q == TICK_W'(TICK_DIV - 1));

   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         tickCnt_q <= '0;
         tick_q    <= 1'b0;
      end
      else
      begin
         tickCnt_q <= tickWrap ? '0 : tickCnt_q + 1'b1;
         tick_q    <= tickWrap;
      end
   end

   // ---------------------------------------------------------------
   // Debounce of key and charger
   // ---------------------------------------------------------------
   logic [TMR_W-1:0] keyCnt_q;
   logic [TMR_W-1:0] chgCnt_q;
   logic             keyOk_q;
   logic             chgOk_q;
   wire              keyDone = (keyCnt_q > TMR_W'(DEBOUNCE_TK));
   wire              chgDone = (chgCnt_q >= TMR_W'(DEBOUNCE_TK));

   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         keyCnt_q <= '0;
         chgCnt_q <= '0;
         keyOk_q  <= 1'b0;
         chgOk_q  <= 1'b0;
      end
      else
      begin
         if (!keyIn)
            keyCnt_q <= '0;
         else if (tick_q && !keyDone)
            keyCnt_q <= keyCnt_q + 1'b1;
         if (!chgIn)
            chgCnt_q <= '0;
         else if (tick_q && !chgDone)
            chgCnt_q <= chgCnt_q + 1'b1;
         keyOk_q <= keyDone;
         chgOk_q <= chgDone;
      end
   end

   // Cycles of unbroken key hold, counted apart from the ticks for a_short_key
   logic [23:0] keyHeld_q;

   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
         keyHeld_q <= '0;
      else if (!keyIn)
         keyHeld_q <= '0;
      else if (!keyHeld_q[23])
         keyHeld_q <= keyHeld_q + 1'b1;
   end

   // One-shot on a fresh acceptance
   wire keyPress = keyDone && !keyOk_q;
   wire chgPlug  = chgDone && !chgOk_q;

   // ---------------------------------------------------------------
   // Sequencer
   // ---------------------------------------------------------------
   hps_state_t       state_q;
   hps_state_t       state_d;
   logic [TMR_W-1:0] tmr_q;
   logic             viaKey_q;
   logic             viaKey_d;

   wire [TMR_W-1:0] ldoDelay = optSel ? TMR_W'(LDO_OPT_TK)
                                      : TMR_W'(LDO_STD_TK);
   wire stateChg  = (state_d != state_q);
   wire railFail  = !first90 || !second90;
   wire holdDrop  = !holdIn && !chgIn;

   always_comb
   begin
      state_d  = state_q;
      viaKey_d = viaKey_q;
      case (state_q)
         ST_OFF:
         begin
            if (keyPress)
            begin
               state_d  = ST_UP1;
               viaKey_d = 1'b1;
            end
            else if (chgPlug)
            begin
               state_d  = ST_UP1;
               viaKey_d = 1'b0;
            end
         end
         ST_UP1:
            if (tmr_q >= ldoDelay)
               state_d = ST_UP2;
         ST_UP2:
            if (first95 && second95)
               state_d = ST_RSTWAIT;
         ST_RSTWAIT:
            if (tmr_q >= TMR_W'(RST_DELAY_TK))
               state_d = ST_HOLDWAIT;
         ST_HOLDWAIT:
         begin
            if (railFail)
               state_d = ST_DN_RST;
            else if (holdIn)
               state_d = ST_ON;
            else if (tmr_q >= TMR_W'(HOLD_MAX_TK) && !chgIn)
               state_d = ST_DN_RST;
         end
         ST_ON:
            if (railFail || holdDrop)
               state_d = ST_DN_RST;
         ST_DN_RST:
            if (tmr_q >= TMR_W'(RST_DELAY_TK))
               state_d = ST_DN2;
         ST_DN2:
            if (tmr_q >= ldoDelay)
               state_d = ST_DN1;
         ST_DN1:
            state_d = ST_OFF;
         default:
            state_d = ST_OFF;
      endcase
   end

   // Timer counts ticks; the delay before the second regulator only starts once the first rail passes 95%,
   // and the delay toward the first regulator's removal only once the second rail has dropped.
   wire tmrHoldZero = (state_q == ST_UP1 && !first95)
                   || (state_q == ST_DN2 && second90);

   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         state_q  <= ST_OFF;
         viaKey_q <= 1'b0;
         tmr_q    <= '0;
      end
      else
      begin
         state_q  <= state_d;
         viaKey_q <= viaKey_d;
         if (stateChg || tmrHoldZero)
            tmr_q <= '0;
         else if (tick_q && tmr_q != {TMR_W{1'b1}})
            tmr_q <= tmr_q + 1'b1;
      end
   end

   // ---------------------------------------------------------------
   // Output decode
   // ---------------------------------------------------------------
   wire enFirst  = (state_d != ST_OFF) && (state_d != ST_DN1);
   wire enSecond = (state_d == ST_UP2) || (state_d == ST_RSTWAIT)
                || (state_d == ST_HOLDWAIT) || (state_d == ST_ON)
                || (state_d == ST_DN_RST);
   // Reset drops with the very first cycle of any rail fault
   wire relReset = ((state_d == ST_HOLDWAIT) || (state_d == ST_ON))
                && !railFail;
   // Wake stays high for a charger start
   wire wakeLow  = viaKey_d && ((state_d == ST_UP1) || (state_d == ST_UP2)
                || (state_d == ST_RSTWAIT) || (state_d == ST_HOLDWAIT));

   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         regEnable      <= '0;
         hostReset_n    <= 1'b0;
         wakeReq_n      <= 1'b1;
         backlight_sink <= 1'b0;
         chargerSeen    <= 1'b0;
      end
      else
      begin
         regEnable.first  <= enFirst;
         regEnable.second <= enSecond;
         hostReset_n      <= relReset;
         wakeReq_n        <= !wakeLow;
         backlight_sink   <= blIn;
         chargerSeen      <= chgIn;
      end
   end

   // ---------------------------------------------------------------
   // Assertions
   // ---------------------------------------------------------------
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);

   a_key_start: assert property (state_q == ST_OFF && keyPress
      |=> regEnable.first && !wakeReq_n)
      else $error("Key press did not start power-up");
   a_short_key: assert property (keyPress |-> keyHeld_q > 24'(DEBOUNCE_TK * TICK_DIV))
      else $error("Key accepted before debounce");
   a_charger_wake: assert property (state_q == ST_OFF && chgPlug && !keyPress
      |=> regEnable.first && wakeReq_n)
      else $error("Charger start lowered wake");
   a_second_order: assert property ($rose(regEnable.second)
      |-> regEnable.first)
      else $error("Second regulator before first");
   a_reset_fault: assert property (hostReset_n && railFail
      |=> !hostReset_n)
      else $error("Rail fault did not assert reset");
   a_hold_wake: assert property (state_q == ST_HOLDWAIT && holdIn && !railFail
      |=> wakeReq_n && hostReset_n)
      else $error("Hold did not clear wake");
   a_hold_timeout: assert property (state_q == ST_HOLDWAIT && !railFail
      && tmr_q >= TMR_W'(HOLD_MAX_TK) && !holdIn && !chgIn
      |=> ##1 !hostReset_n && wakeReq_n)
      else $error("Hold timeout did not power down");
   a_power_off: assert property (state_q == ST_ON && holdDrop && !railFail
      |=> ##1 !hostReset_n && regEnable.second)
      else $error("Hold drop not answered by reset");
   a_charger_keep: assert property (state_q == ST_ON && chgIn && !railFail
      |=> state_q == ST_ON)
      else $error("Powered down with charger present");
   a_backlight: assert property (backlight_sink == $past(blIn))
      else $error("Backlight not following enable");
   a_dn_second: assert property (state_q == ST_DN_RST && stateChg
      |-> tmr_q >= TMR_W'(RST_DELAY_TK))
      else $error("Second regulator off too early");

   c_key_up:    cover property (state_q == ST_HOLDWAIT && viaKey_q ##1 state_q == ST_ON);
   c_chg_up:    cover property (state_q == ST_HOLDWAIT && !viaKey_q ##1 state_q == ST_ON);
   c_power_dn:  cover property (state_q == ST_DN1 ##1 state_q == ST_OFF);

endmodule : hps_sequencer

`default_nettype wire

// [tb/hps_host_model.sv]
// Model of the host processor and the two rail comparators
`timescale 1ns/1ns
`default_nettype none

module hps_host_model
   import hps_pkg::*;
(
   // Clock and reset
   input  wire logic       clk,
   input  wire logic       rst,
   // From the sequencer
   input  wire hps_regs_t  regEnable,
   input  wire logic       hostReset_n,
   // Host intent, set by the bench
   input  wire logic       holdReq,
   // Toward the sequencer
   output var  hps_rails_t railFlags,
   output var  logic       host_power_hold
);
   logic [63:0] ramp1_q;
   logic [63:0] ramp2_q;
   logic [7:0]  bootCnt_q;

   // Rails take 64 cycles to settle, far shorter than real ones, to keep runs short
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         ramp1_q   <= '0;
         ramp2_q   <= '0;
         bootCnt_q <= 8'h00;
         host_power_hold <= 1'b0;
      end
      else
      begin
         ramp1_q <= {ramp1_q[62:0], regEnable.first};
         ramp2_q <= {ramp2_q[62:0], regEnable.second};
         bootCnt_q <= !hostReset_n ? 8'h00 : (bootCnt_q == 8'h64) ? bootCnt_q : bootCnt_q + 8'h01;
         // Host holds power once booted, drops it on request or when reset again
         host_power_hold <= holdReq && hostReset_n && bootCnt_q == 8'h64;
      end
   end

   // Rising rail passes 90% before 95%, a falling one 95% before 90%
   always_comb
   begin
      railFlags.first90  = ramp1_q[47] | ramp1_q[63];
      railFlags.first95  = ramp1_q[47] & ramp1_q[63];
      railFlags.second90 = ramp2_q[47] | ramp2_q[63];
      railFlags.second95 = ramp2_q[47] & ramp2_q[63];
   end
endmodule : hps_host_model

`default_nettype wire

// [tb/tb_hps_sequencer.sv]
// Self-checking testbench of the handset power sequencer
`timescale 1ns/1ns
`default_nettype none

module tb_hps_sequencer
   import hps_pkg::*;
   ;
   // One tick per cycle keeps every delay short enough to run in full
   localparam int TB_TICK = 1;
   localparam int DBN  = DEBOUNCE_TK * TB_TICK;
   localparam int LDO  = 64 + LDO_STD_TK * TB_TICK;
   localparam int LDOX = 64 + LDO_OPT_TK * TB_TICK;
   localparam int RSTD = RST_DELAY_TK * TB_TICK;

   logic       clk = 1'b0;
   logic       rst = 1'b1;
   logic       power_key_in = 1'b0;
   logic       charger_detect_n = 1'b1;
   logic       backlight_enable = 1'b0;
   logic       optDelaySel = 1'b0;
   logic       holdReq = 1'b0;
   logic       host_power_hold;
   hps_rails_t railFlags;
   hps_regs_t  regEnable;
   logic       hostReset_n;
   logic       wakeReq_n;
   logic       backlight_sink;
   logic       chargerSeen;
   int         n_fail = 0;
   int         compares = 0;
   int         n;

   always #4 clk = ~clk;

   hps_sequencer #(.TICK_DIV(TB_TICK)) i_hps_sequencer (
      .clk(clk), .rst(rst), .power_key_in(power_key_in),
      .charger_detect_n(charger_detect_n), .host_power_hold(host_power_hold),
      .backlight_enable(backlight_enable), .optDelaySel(optDelaySel), .railFlags(railFlags),
      .regEnable(regEnable), .hostReset_n(hostReset_n), .wakeReq_n(wakeReq_n),
      .backlight_sink(backlight_sink), .chargerSeen(chargerSeen));

   hps_host_model i_hps_host_model (
      .clk(clk), .rst(rst), .regEnable(regEnable), .hostReset_n(hostReset_n),
      .holdReq(holdReq), .railFlags(railFlags), .host_power_hold(host_power_hold));

   // ---------------------------------------------------------------
   // Helpers
   // ---------------------------------------------------------------
   task automatic step(input int k);
      repeat (k) @(posedge clk);
      #1;
   endtask : step

   task automatic print_verdict();
      $display("checks %0d mismatches %0d", compares, n_fail);
      if (n_fail == 0 && compares > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask : print_verdict

   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      compares++;
      if (seen !== exp)
      begin
         n_fail++;
         $display("mismatch %s expected %0h seen %0h", what, exp, seen);
      end
   endtask : check

   // Input sync and the debounce edge shift every delay by a few cycles
   function automatic logic near(input int got, input int exp);
      return (got >= exp - 16) && (got <= exp + 16);
   endfunction : near

   task automatic waitOn(input int sel, input logic val, input int maxc, output int k);
      logic s;
      for (k = 0; k < maxc; k++)
      begin
         case (sel)
            0: s = regEnable.first;
            1: s = regEnable.second;
            2: s = hostReset_n;
            default: s = wakeReq_n;
         endcase
         if (s === val)
            return;
         step(1);
      end
      n_fail++;
      $display("mismatch wait%0d expected %0h seen %0h", sel, val, s);
      print_verdict();
   endtask : waitOn

   // ---------------------------------------------------------------
   // Scenarios
   // ---------------------------------------------------------------
   task automatic testBacklight();
      backlight_enable = 1'b1;
      step(10);
      check("sinkOn", backlight_sink, 1);
      backlight_enable = 1'b0;
      step(10);
      check("sinkOff", backlight_sink, 0);
      $display("test backlight done");
   endtask : testBacklight

   task automatic testGlitch();
      power_key_in = 1'b1;
      step(1000);
      power_key_in = 1'b0;
      charger_detect_n = 1'b0;
      step(1000);
      charger_detect_n = 1'b1;
      step(200);
      check("glitchRegs", regEnable, 2'b00);
      check("glitchWake", wakeReq_n, 1);
      $display("test glitch done");
   endtask : testGlitch

   task automatic testPowerUp();
      power_key_in = 1'b1;
      holdReq = 1'b1;
      waitOn(0, 1'b1, DBN + 500, n);
      check("debounce", near(n, DBN), 1);
      check("wakeLow", wakeReq_n, 0);
      check("secondOff", regEnable.second, 0);
      power_key_in = 1'b0;
      waitOn(1, 1'b1, LDO + 500, n);
      check("ldoDelay", near(n, LDO), 1);
      waitOn(2, 1'b1, 64 + RSTD + 500, n);
      check("rstDelay", near(n, 64 + RSTD), 1);
      check("wakeHeld", wakeReq_n, 0);
      waitOn(3, 1'b1, 300, n);
      check("holdSeen", host_power_hold, 1);
      $display("test power up done");
   endtask : testPowerUp

   task automatic testChargerDown();
      charger_detect_n = 1'b0;
      step(100);
      check("chgSeen", chargerSeen, 1);
      check("chgRegs", regEnable, 2'b11);
      check("chgWake", wakeReq_n, 1);
      holdReq = 1'b0;
      step(2000);
      check("stayOn", hostReset_n, 1);
      optDelaySel = 1'b1;
      charger_detect_n = 1'b1;
      waitOn(2, 1'b0, 40, n);
      waitOn(1, 1'b0, RSTD + 500, n);
      check("dnDelay", near(n, RSTD), 1);
      check("firstStill", regEnable.first, 1);
      waitOn(0, 1'b0, LDOX + 500, n);
      check("dnLdo", near(n, LDOX), 1);
      check("chgGone", chargerSeen, 0);
      $display("test power down done");
   endtask : testChargerDown

   initial
   begin
      step(5);
      check("rstRegs", regEnable, 2'b00);
      check("rstHost", hostReset_n, 0);
      rst = 1'b0;
      step(5);
      check("idleWake", wakeReq_n, 1);
      $display("test reset done");
      testBacklight();
      testGlitch();
      testPowerUp();
      testChargerDown();
      print_verdict();
   end
endmodule : tb_hps_sequencer

`default_nettype wire
